/* File: hw/imcb_pkg.sv */
// What this block does
// - Probe errors never raise a code access exception; they only set status bits and the physical address.
// - Invalid descriptor in probe walk aborts, sets segment/page invalid, stores address.
// - Bus error in probe walk aborts, sets walk bus error, stores failing address.
// - Two breakpoint registers, selected by page index 32 and 33.
// - Breakpoints match only when breakpoint enable is set; reset clears it.
// - Upper port writes are buffered and committed on the next lower write.
// - Upper breakpoint word holds a fully writable 32-bit address.
// - Lower word holds privilege, direction, valid and their two masks.
// - Four cumulative range masks widen compare from bits 31-0 to 31-4.
// - Compare ignores address bits below the access granularity.
// - Enabled valid matching fetch sets breakpoint hit and raises code exception.
// - Control registers take load and store, never exchange.
// - Command write starts action in bits 4-0; command reads return zero.
// - Command codes: nop, target inval, both inval, line, probes, ATC invals.
// - Cache enable clear bypasses instruction cache; reset clears it.
// - Target cache enable clear bypasses target cache; reset clears it.
// - SRAM test mode maps one array only; reset leaves both out.
// - Translation disabled gives identity mapping with area pointer attributes.
// - Walk enable set (default) walks on miss; clear traps to miss vector.
// - Lock bits freeze line 0 or line 1 of every set.
// - Seven thermometer block-size bits: zero 512KB up to all ones 64MB.
//
// Purpose: constants and carriers for the instruction MMU control block
// Assumes: core control-register port, one clock
// Notes: control register numbers are local selects
package imcb_pkg;
	// Control register selects
	localparam logic [3:0] SEL_COMMAND = 4'h0;
	localparam logic [3:0] SEL_CONTROL = 4'h1;
	localparam logic [3:0] SEL_STATUS = 4'h2;
	localparam logic [3:0] SEL_PHYS_ADDR = 4'h3;
	localparam logic [3:0] SEL_SYS_ADDR = 4'h4;
	localparam logic [3:0] SEL_INDEX = 4'h5;
	localparam logic [3:0] SEL_PORT_UPPER = 4'h6;
	localparam logic [3:0] SEL_PORT_LOWER = 4'h7;
	// Control register fields
	localparam int CTL_ICACHE_EN = 0;
	localparam int CTL_TARGET_EN = 1;
	localparam int CTL_ICACHE_SRAM = 2;
	localparam int CTL_TARGET_SRAM = 3;
	localparam int CTL_XLATE_EN = 4;
	localparam int CTL_WALK_EN = 5;
	localparam int CTL_LOCK0 = 6;
	localparam int CTL_LOCK1 = 7;
	localparam int CTL_BP_EN = 8;
	localparam int CTL_BSIZE_LSB = 9;
	localparam logic [31:0] CTL_WRITABLE = 32'h0000_FFFF;
	localparam logic [31:0] CTL_RESET = 32'h0000_0020;
	// Status fields
	localparam int ST_SEG_INV = 0;
	localparam int ST_PAGE_INV = 1;
	localparam int ST_WALK_BERR = 2;
	localparam int ST_BP_HIT = 3;
	// Index register
	localparam logic [5:0] BP0_INDEX = 6'h20;
	localparam logic [5:0] BP1_INDEX = 6'h21;
	localparam int IDX_LSB = 0;
	// Breakpoint lower word fields
	localparam int BPL_VALID = 0;
	localparam int BPL_PRIV = 1;
	localparam int BPL_DIR = 2;
	localparam int BPL_PRIV_MASK = 3;
	localparam int BPL_DIR_MASK = 4;
	localparam int BPL_RANGE_LSB = 5;
	localparam logic [31:0] BPL_WRITABLE = 32'h0000_01FF;
	// Command codes
	localparam logic [4:0] CMD_NOP = 5'h00;
	localparam logic [4:0] CMD_INV_TARGET = 5'h02;
	localparam logic [4:0] CMD_INV_BOTH = 5'h03;
	localparam logic [4:0] CMD_INV_LINE = 5'h04;
	localparam logic [4:0] CMD_PROBE_SUP = 5'h08;
	localparam logic [4:0] CMD_PROBE_USR = 5'h09;
	localparam logic [4:0] CMD_INV_ATC_SUP = 5'h0A;
	localparam logic [4:0] CMD_INV_ATC_USR = 5'h0B;
	// Access sizes
	typedef enum logic [2:0] {
		IMCB_SZ_BYTE = 3'b000,
		IMCB_SZ_HALF = 3'b001,
		IMCB_SZ_WORD = 3'b010,
		IMCB_SZ_DBL = 3'b011,
		IMCB_SZ_QUAD = 3'b100
	} imcb_size_t;
	// One breakpoint entry
	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] lower;
	} imcb_bp_t;
	// Fetch presented for breakpoint compare
	typedef struct packed {
		logic valid;
		logic [31:0] addr;
		logic priv;
		logic dir;
		imcb_size_t size;
	} imcb_fetch_t;
	// Probe walk outcome
	typedef struct packed {
		logic done;
		logic seg_inv;
		logic page_inv;
		logic bus_err;
		logic [31:0] phys;
	} imcb_probe_t;
	// Command pulses
	typedef struct packed {
		logic inv_target;
		logic inv_icache;
		logic inv_line;
		logic probe_sup;
		logic probe_usr;
		logic inv_atc_sup;
		logic inv_atc_usr;
	} imcb_cmd_t;
	// Whole block state
	typedef struct packed {
		logic [31:0] control;
		logic [31:0] status;
		logic [31:0] phys_addr;
		logic [31:0] sys_addr;
		logic [31:0] index;
		logic [31:0] upper_buf;
		imcb_bp_t bp0;
		imcb_bp_t bp1;
		logic [31:0] rdata;
		imcb_cmd_t cmd;
		logic code_exc;
	} imcb_state_t;
endpackage

/* File: hw/imcb_ctrl.sv */
// Purpose: instruction MMU command, control, status and breakpoint registers
// Assumes: core issues one control-register load or store per cycle
// Notes: exchange requests are refused; read data is registered
module imcb_ctrl (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	input wire logic clk_en,
	// Control register port from the core
	input wire logic cr_store,
	input wire logic cr_load,
	input wire logic cr_exchange,
	input wire logic [3:0] cr_sel,
	input wire logic [31:0] cr_wdata,
	output logic [31:0] cr_rdata,
	output logic cr_refused,
	// Fetch stream and probe walker
	input imcb_pkg::imcb_fetch_t fetch,
	input imcb_pkg::imcb_probe_t probe,
	// Commands and controls out
	output imcb_pkg::imcb_cmd_t cmd,
	output logic icache_active,
	output logic target_active,
	output logic icache_sram_map,
	output logic target_sram_map,
	output logic [31:0] sram_base,
	output logic identity_xlate,
	output logic walk_on_miss,
	output logic trap_on_miss,
	output logic [1:0] lock_lines,
	output logic [6:0] block_size_bits,
	output logic code_exc
);
	imcb_pkg::imcb_state_t s_reg, s_next;
	logic [5:0] idx;
	logic hit0, hit1;

	////////////////////////////////////////////////////////////////////////////
	// Breakpoint compare, one function for both entries
	function automatic logic bp_match(input imcb_pkg::imcb_bp_t e, input imcb_pkg::imcb_fetch_t f);
		logic [31:0] mask;
		logic [3:0] rng;
		logic [2:0] gran;
		logic [2:0] low;
		mask = 32'hFFFF_FFFF;
		rng = e.lower[imcb_pkg::BPL_RANGE_LSB +: 4];
		gran = f.size;
		// Range masks are cumulative, so count the ones in order
		low = 3'h0;
		if (rng[0]) low = 3'h1;
		if (rng[0] && rng[1]) low = 3'h2;
		if (rng[0] && rng[1] && rng[2]) low = 3'h3;
		if (rng[0] && rng[1] && rng[2] && rng[3]) low = 3'h4;
		// Coarser of range and access granularity wins
		if (gran > low) low = gran;
		mask = 32'hFFFF_FFFF << low;
		bp_match = e.lower[imcb_pkg::BPL_VALID]
			&& ((f.addr & mask) == (e.addr & mask))
			&& (e.lower[imcb_pkg::BPL_PRIV_MASK] || (e.lower[imcb_pkg::BPL_PRIV] == f.priv))
			&& (e.lower[imcb_pkg::BPL_DIR_MASK] || (e.lower[imcb_pkg::BPL_DIR] == f.dir));
	endfunction

	assign idx = s_reg.index[imcb_pkg::IDX_LSB +: 6];
	assign hit0 = bp_match(s_reg.bp0, fetch);
	assign hit1 = bp_match(s_reg.bp1, fetch);

	////////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		logic st, ld;
		st = cr_store && !cr_exchange;
		ld = cr_load && !cr_exchange;
		s_next = s_reg;
		s_next.cmd = '0;
		s_next.code_exc = 1'b0;
		// Command decode; reserved codes fall through as no-ops
		if (st && cr_sel == imcb_pkg::SEL_COMMAND) begin
			case (cr_wdata[4:0])
				imcb_pkg::CMD_INV_TARGET: s_next.cmd.inv_target = 1'b1;
				imcb_pkg::CMD_INV_BOTH: begin
					s_next.cmd.inv_target = 1'b1;
					s_next.cmd.inv_icache = 1'b1;
				end
				imcb_pkg::CMD_INV_LINE: s_next.cmd.inv_line = 1'b1;
				imcb_pkg::CMD_PROBE_SUP: s_next.cmd.probe_sup = 1'b1;
				imcb_pkg::CMD_PROBE_USR: s_next.cmd.probe_usr = 1'b1;
				imcb_pkg::CMD_INV_ATC_SUP: s_next.cmd.inv_atc_sup = 1'b1;
				imcb_pkg::CMD_INV_ATC_USR: s_next.cmd.inv_atc_usr = 1'b1;
				default: s_next.cmd = '0;
			endcase
		end else if (st && cr_sel == imcb_pkg::SEL_CONTROL) begin
			s_next.control = cr_wdata & imcb_pkg::CTL_WRITABLE;
			// Only one array may be mapped; the cache keeps priority
			if (cr_wdata[imcb_pkg::CTL_ICACHE_SRAM]) begin
				s_next.control[imcb_pkg::CTL_TARGET_SRAM] = 1'b0;
			end
		end else if (st && cr_sel == imcb_pkg::SEL_STATUS) begin
			s_next.status = cr_wdata & 32'h0000_000F;
		end else if (st && cr_sel == imcb_pkg::SEL_PHYS_ADDR) begin
			s_next.phys_addr = cr_wdata;
		end else if (st && cr_sel == imcb_pkg::SEL_SYS_ADDR) begin
			s_next.sys_addr = cr_wdata;
		end else if (st && cr_sel == imcb_pkg::SEL_INDEX) begin
			s_next.index = cr_wdata & 32'h0000_003F;
		end else if (st && cr_sel == imcb_pkg::SEL_PORT_UPPER) begin
			s_next.upper_buf = cr_wdata;
		end else if (st && cr_sel == imcb_pkg::SEL_PORT_LOWER) begin
			// Lower write commits the buffered upper word too
			if (idx == imcb_pkg::BP0_INDEX) begin
				s_next.bp0.addr = s_reg.upper_buf;
				s_next.bp0.lower = cr_wdata & imcb_pkg::BPL_WRITABLE;
			end else if (idx == imcb_pkg::BP1_INDEX) begin
				s_next.bp1.addr = s_reg.upper_buf;
				s_next.bp1.lower = cr_wdata & imcb_pkg::BPL_WRITABLE;
			end
		end
		// Register reads; command reads zero, unmapped reads zero
		if (ld) begin
			if (cr_sel == imcb_pkg::SEL_CONTROL) begin
				s_next.rdata = s_reg.control;
			end else if (cr_sel == imcb_pkg::SEL_STATUS) begin
				s_next.rdata = s_reg.status;
			end else if (cr_sel == imcb_pkg::SEL_PHYS_ADDR) begin
				s_next.rdata = s_reg.phys_addr;
			end else if (cr_sel == imcb_pkg::SEL_SYS_ADDR) begin
				s_next.rdata = s_reg.sys_addr;
			end else if (cr_sel == imcb_pkg::SEL_INDEX) begin
				s_next.rdata = s_reg.index;
			end else if (cr_sel == imcb_pkg::SEL_PORT_LOWER && idx == imcb_pkg::BP0_INDEX) begin
				s_next.rdata = s_reg.bp0.lower;
			end else if (cr_sel == imcb_pkg::SEL_PORT_LOWER && idx == imcb_pkg::BP1_INDEX) begin
				s_next.rdata = s_reg.bp1.lower;
			end else if (cr_sel == imcb_pkg::SEL_PORT_UPPER && idx == imcb_pkg::BP0_INDEX) begin
				s_next.rdata = s_reg.bp0.addr;
			end else if (cr_sel == imcb_pkg::SEL_PORT_UPPER && idx == imcb_pkg::BP1_INDEX) begin
				s_next.rdata = s_reg.bp1.addr;
			end else begin
				s_next.rdata = 32'h0000_0000;
			end
		end
		// Probe errors only touch status and the physical address, never the exception line
		if (probe.done) begin
			if (probe.seg_inv || probe.page_inv) begin
				s_next.status[imcb_pkg::ST_SEG_INV] = probe.seg_inv;
				s_next.status[imcb_pkg::ST_PAGE_INV] = probe.page_inv;
				s_next.phys_addr = probe.phys;
			end
			if (probe.bus_err) begin
				s_next.status[imcb_pkg::ST_WALK_BERR] = 1'b1;
				s_next.phys_addr = probe.phys;
			end
		end
		// Breakpoint hit sets status after software writes, so set wins
		if (fetch.valid && s_reg.control[imcb_pkg::CTL_BP_EN] && (hit0 || hit1)) begin
			s_next.status[imcb_pkg::ST_BP_HIT] = 1'b1;
			s_next.code_exc = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// State register, frozen while the clock enable is low
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s_reg <= '0;
			s_reg.control <= imcb_pkg::CTL_RESET;
		end else if (clk_en) begin
			s_reg <= s_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs to caches and translation logic
	assign cr_rdata = s_reg.rdata;
	assign cr_refused = cr_exchange && (cr_store || cr_load);
	assign cmd = s_reg.cmd;
	assign code_exc = s_reg.code_exc;
	assign icache_sram_map = s_reg.control[imcb_pkg::CTL_ICACHE_SRAM];
	assign target_sram_map = s_reg.control[imcb_pkg::CTL_TARGET_SRAM];
	assign icache_active = s_reg.control[imcb_pkg::CTL_ICACHE_EN] && !icache_sram_map;
	assign target_active = s_reg.control[imcb_pkg::CTL_TARGET_EN] && !target_sram_map;
	assign sram_base = s_reg.sys_addr;
	assign identity_xlate = !s_reg.control[imcb_pkg::CTL_XLATE_EN];
	assign walk_on_miss = s_reg.control[imcb_pkg::CTL_WALK_EN];
	assign trap_on_miss = !s_reg.control[imcb_pkg::CTL_WALK_EN];
	assign lock_lines = {s_reg.control[imcb_pkg::CTL_LOCK1], s_reg.control[imcb_pkg::CTL_LOCK0]};
	assign block_size_bits = s_reg.control[imcb_pkg::CTL_BSIZE_LSB +: 7];
endmodule // imcb_ctrl

/* File: test/imcb_ctrl_assertions.sv */
// Purpose: port checks of the instruction MMU control block
// Assumes: state moves only on edges with clk_en high
// Notes: bound to every imcb_ctrl
module imcb_ctrl_assertions (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	input wire logic clk_en,
	// Core port
	input wire logic cr_store,
	input wire logic cr_load,
	input wire logic cr_exchange,
	input wire logic [3:0] cr_sel,
	input wire logic [31:0] cr_wdata,
	input wire logic [31:0] cr_rdata,
	input wire logic cr_refused,
	// Block side
	input wire imcb_pkg::imcb_fetch_t fetch,
	input wire imcb_pkg::imcb_probe_t probe,
	input wire imcb_pkg::imcb_cmd_t cmd,
	input wire logic icache_sram_map,
	input wire logic target_sram_map,
	input wire logic walk_on_miss,
	input wire logic trap_on_miss,
	input wire logic code_exc
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	// Codes that start an action; all others must stay silent
	logic live_code;
	assign live_code = cr_wdata[4:0] inside {5'h02, 5'h03, 5'h04, 5'h08, 5'h09, 5'h0A, 5'h0B};
	// Accepted command store of one code
	sequence cmd_st(logic [4:0] c);
		clk_en && cr_store && !cr_exchange && cr_sel == imcb_pkg::SEL_COMMAND && cr_wdata[4:0] == c;
	endsequence
	sequence any_cmd_st;
		clk_en && cr_store && !cr_exchange && cr_sel == imcb_pkg::SEL_COMMAND;
	endsequence
	refuse_xcr_a: assert property (cr_exchange && (cr_store || cr_load) |-> cr_refused)
		else $error("exchange not refused");
	xcr_quiet_a: assert property (clk_en && cr_exchange && cr_store |=> cmd == '0)
		else $error("exchange started a command");
	both_inval_a: assert property (cmd_st(imcb_pkg::CMD_INV_BOTH) |=> cmd.inv_target && cmd.inv_icache)
		else $error("invalidate both missing");
	user_probe_a: assert property (cmd_st(imcb_pkg::CMD_PROBE_USR) |=> cmd.probe_usr && !cmd.probe_sup)
		else $error("user probe wrong");
	idle_cmd_a: assert property (any_cmd_st ##0 !live_code |=> cmd == '0)
		else $error("reserved code acted");
	cmd_zero_a: assert property (clk_en && cr_load && !cr_exchange && cr_sel == 4'h0 |=> cr_rdata == '0)
		else $error("command read not zero");
	probe_quiet_a: assert property (clk_en && probe.done && !fetch.valid |=> !code_exc)
		else $error("probe raised exception");
	sram_single_a: assert property (!(icache_sram_map && target_sram_map))
		else $error("both arrays mapped");
	walk_split_a: assert property (walk_on_miss != trap_on_miss)
		else $error("walk and trap agree");
	// Pulses only follow an accepted command store or a presented fetch
	cmd_source_a: assert property (clk_en && !(cr_store && !cr_exchange
		&& cr_sel == imcb_pkg::SEL_COMMAND) |=> cmd == '0)
		else $error("command pulse without store");
	exc_source_a: assert property (clk_en && !fetch.valid |=> !code_exc)
		else $error("exception without fetch");
endmodule // imcb_ctrl_assertions
bind imcb_ctrl imcb_ctrl_assertions imcb_ctrl_assertions_inst (.clk(clk), .reset_n(reset_n),
	.clk_en(clk_en), .cr_store(cr_store), .cr_load(cr_load), .cr_exchange(cr_exchange),
	.cr_sel(cr_sel), .cr_wdata(cr_wdata), .cr_rdata(cr_rdata), .cr_refused(cr_refused),
	.fetch(fetch), .probe(probe), .cmd(cmd), .icache_sram_map(icache_sram_map),
	.target_sram_map(target_sram_map), .walk_on_miss(walk_on_miss),
	.trap_on_miss(trap_on_miss), .code_exc(code_exc));

/* File: test/imcb_core_model.sv */
// Purpose: core side issuing control register loads and stores
// Assumes: one request per call, taken on the next edge
// Notes: released data shows the inverse so stale values never pass
module imcb_core_model (
	// Clock
	input wire logic clk,
	// Control register port
	output logic cr_store,
	output logic cr_load,
	output logic cr_exchange,
	output logic [3:0] cr_sel,
	output logic [31:0] cr_wdata,
	input wire logic [31:0] cr_rdata
);
	timeunit 1ns;
	timeprecision 100ps;
	// Idle port at time zero
	initial begin
		{cr_store, cr_load, cr_exchange, cr_sel, cr_wdata} = '0;
	end
	// One store, load or exchange; read data stands after the taking edge
	task automatic xfer(input logic st, input logic ld, input logic xc, input logic [3:0] s,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge clk);
		#1;
		{cr_store, cr_load, cr_exchange, cr_sel, cr_wdata} = {st, ld, xc, s, d};
		@(posedge clk);
		#1;
		q = cr_rdata;
		{cr_store, cr_load, cr_exchange, cr_wdata} = {3'b000, ~d};
	endtask
endmodule // imcb_core_model

/* File: test/instr_mmu_control_breakpoints_test.sv */
// Purpose: register level bench of the instruction MMU control block
// Assumes: clk_en high apart from one freeze check
// Notes: status bits are masked since they accumulate
module instr_mmu_control_breakpoints_test;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0, reset_n, cr_store, cr_load, cr_exchange, cr_refused, code_exc;
	logic icache_active, target_active, icache_sram_map, target_sram_map;
	logic identity_xlate, walk_on_miss, trap_on_miss;
	logic clk_en;
	logic [6:0] exp_cmd;
	logic [3:0] cr_sel;
	logic [31:0] cr_wdata, cr_rdata, sram_base, q;
	logic [1:0] lock_lines;
	logic [6:0] block_size_bits;
	imcb_pkg::imcb_fetch_t fetch;
	imcb_pkg::imcb_probe_t probe;
	imcb_pkg::imcb_cmd_t cmd;
	int failures = 0, total_checks = 0;
	always #10 clk = ~clk;
	imcb_ctrl imcb_ctrl_inst (.clk(clk), .reset_n(reset_n), .clk_en(clk_en), .cr_store(cr_store),
		.cr_load(cr_load), .cr_exchange(cr_exchange), .cr_sel(cr_sel), .cr_wdata(cr_wdata),
		.cr_rdata(cr_rdata), .cr_refused(cr_refused), .fetch(fetch), .probe(probe), .cmd(cmd),
		.icache_active(icache_active), .target_active(target_active),
		.icache_sram_map(icache_sram_map), .target_sram_map(target_sram_map),
		.sram_base(sram_base), .identity_xlate(identity_xlate), .walk_on_miss(walk_on_miss),
		.trap_on_miss(trap_on_miss), .lock_lines(lock_lines),
		.block_size_bits(block_size_bits), .code_exc(code_exc));
	imcb_core_model imcb_core_model_inst (.clk(clk), .cr_store(cr_store), .cr_load(cr_load),
		.cr_exchange(cr_exchange), .cr_sel(cr_sel), .cr_wdata(cr_wdata), .cr_rdata(cr_rdata));
	////////////////////////////////////////////////////////////////////////////////
	// Compare, access and stimulus tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] s, input logic [31:0] d);
		imcb_core_model_inst.xfer(1'b1, 1'b0, 1'b0, s, d, q);
	endtask
	task automatic rdc(input logic [3:0] s, input logic [31:0] mask, input logic [31:0] exp);
		imcb_core_model_inst.xfer(1'b0, 1'b1, 1'b0, s, 32'h0, q);
		chk(q & mask, exp);
	endtask
	task automatic fire(input logic [31:0] a, input logic p, input logic d,
		input imcb_pkg::imcb_size_t sz, input logic exp);
		@(posedge clk);
		#1;
		fetch = '{valid: 1'b1, addr: a, priv: p, dir: d, size: sz};
		@(posedge clk);
		#1;
		fetch = '{valid: 1'b0, addr: ~a, priv: ~p, dir: ~d, size: sz};
		chk({31'h0, code_exc}, {31'h0, exp});
	endtask
	task automatic prb(input logic s, input logic pg, input logic be, input logic [31:0] ph);
		@(posedge clk);
		#1;
		probe = '{1'b1, s, pg, be, ph};
		@(posedge clk);
		#1;
		probe = '{1'b0, 1'b0, 1'b0, 1'b0, ~ph};
	endtask
	task automatic complete_run();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Hang guard: a stuck run still reaches the verdict
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		complete_run();
	end
	// Main sequence
	initial begin
		{reset_n, fetch, probe} = '0;
		clk_en = 1'b1;
		repeat (16) @(posedge clk);
		#1 reset_n = 1'b1;
		rdc(imcb_pkg::SEL_CONTROL, '1, imcb_pkg::CTL_RESET);
		chk({30'h0, walk_on_miss, identity_xlate}, 32'h3);
		rdc(4'h8, '1, 32'h0);
		wr(imcb_pkg::SEL_CONTROL, 32'hFFFF_7E9B);
		rdc(imcb_pkg::SEL_CONTROL, '1, 32'h0000_7E9B);
		chk({22'h0, block_size_bits, lock_lines, trap_on_miss}, 32'h0000_01FD);
		chk({28'h0, icache_active, target_active, target_sram_map, identity_xlate}, 32'hA);
		wr(imcb_pkg::SEL_CONTROL, 32'h0000_000C);
		rdc(imcb_pkg::SEL_CONTROL, '1, 32'h0000_0004);
		// A store while the clock enable is low must be lost
		clk_en = 1'b0;
		wr(imcb_pkg::SEL_CONTROL, 32'h0000_0001);
		clk_en = 1'b1;
		imcb_core_model_inst.xfer(1'b1, 1'b0, 1'b1, imcb_pkg::SEL_CONTROL, 32'h0, q);
		rdc(imcb_pkg::SEL_CONTROL, '1, 32'h0000_0004);
		// Every command code, with junk above the code field
		for (int i = 0; i < 32; i++) begin
			wr(imcb_pkg::SEL_COMMAND, 32'hFFFF_FFE0 | i);
			case (i[4:0])
				imcb_pkg::CMD_INV_TARGET: exp_cmd = 7'h40;
				imcb_pkg::CMD_INV_BOTH: exp_cmd = 7'h60;
				imcb_pkg::CMD_INV_LINE: exp_cmd = 7'h10;
				imcb_pkg::CMD_PROBE_SUP: exp_cmd = 7'h08;
				imcb_pkg::CMD_PROBE_USR: exp_cmd = 7'h04;
				imcb_pkg::CMD_INV_ATC_SUP: exp_cmd = 7'h02;
				imcb_pkg::CMD_INV_ATC_USR: exp_cmd = 7'h01;
				default: exp_cmd = 7'h00;
			endcase
			chk({25'h0, cmd}, {25'h0, exp_cmd});
		end
		imcb_core_model_inst.xfer(1'b1, 1'b0, 1'b1, imcb_pkg::SEL_COMMAND, 32'h3, q);
		rdc(imcb_pkg::SEL_COMMAND, '1, 32'h0);
		wr(imcb_pkg::SEL_SYS_ADDR, 32'h00C0_0000);
		chk(sram_base, 32'h00C0_0000);
		// Probe errors only land in status and address
		prb(1'b1, 1'b0, 1'b0, 32'h0000_4440);
		chk({31'h0, code_exc}, 32'h0);
		rdc(imcb_pkg::SEL_PHYS_ADDR, '1, 32'h0000_4440);
		rdc(imcb_pkg::SEL_STATUS, '1, 32'h1);
		prb(1'b0, 1'b0, 1'b1, 32'h0000_8880);
		rdc(imcb_pkg::SEL_PHYS_ADDR, '1, 32'h0000_8880);
		rdc(imcb_pkg::SEL_STATUS, 32'h4, 32'h4);
		prb(1'b0, 1'b1, 1'b0, 32'h0000_2220);
		rdc(imcb_pkg::SEL_STATUS, 32'h2, 32'h2);
		// Breakpoint loading; a lone upper write must not commit
		wr(imcb_pkg::SEL_INDEX, 32'h21);
		wr(imcb_pkg::SEL_PORT_UPPER, 32'hA5A5_5A5B);
		wr(imcb_pkg::SEL_PORT_LOWER, 32'hFFFF_FE1F);
		wr(imcb_pkg::SEL_PORT_UPPER, 32'h1111_1111);
		rdc(imcb_pkg::SEL_PORT_LOWER, '1, 32'h0000_001F);
		rdc(imcb_pkg::SEL_PORT_UPPER, '1, 32'hA5A5_5A5B);
		wr(imcb_pkg::SEL_INDEX, 32'h20);
		wr(imcb_pkg::SEL_PORT_UPPER, 32'h0000_1003);
		wr(imcb_pkg::SEL_PORT_LOWER, 32'h0000_0073);
		fire(32'h0000_1000, 1'b1, 1'b0, imcb_pkg::IMCB_SZ_BYTE, 1'b0);
		wr(imcb_pkg::SEL_CONTROL, 32'h0000_0120);
		fire(32'h0000_1000, 1'b1, 1'b0, imcb_pkg::IMCB_SZ_BYTE, 1'b1);
		rdc(imcb_pkg::SEL_STATUS, 32'h8, 32'h8);
		fire(32'h0000_1004, 1'b1, 1'b0, imcb_pkg::IMCB_SZ_BYTE, 1'b0);
		fire(32'h0000_1000, 1'b0, 1'b0, imcb_pkg::IMCB_SZ_BYTE, 1'b0);
		fire(32'h0000_1000, 1'b1, 1'b1, imcb_pkg::IMCB_SZ_BYTE, 1'b1);
		fire(32'h0000_100C, 1'b1, 1'b0, imcb_pkg::IMCB_SZ_QUAD, 1'b1);
		fire(32'h0000_100C, 1'b1, 1'b0, imcb_pkg::IMCB_SZ_WORD, 1'b0);
		fire(32'hA5A5_5A5B, 1'b0, 1'b0, imcb_pkg::IMCB_SZ_BYTE, 1'b1);
		fire(32'hA5A5_5A5A, 1'b1, 1'b0, imcb_pkg::IMCB_SZ_HALF, 1'b1);
		wr(imcb_pkg::SEL_CONTROL, 32'h0000_0020);
		fire(32'h0000_1000, 1'b1, 1'b0, imcb_pkg::IMCB_SZ_BYTE, 1'b0);
		complete_run();
	end
endmodule // instr_mmu_control_breakpoints_test
